// file: hw/asc_sweep_ctrl.sv
// Converter control: Wishbone registers, triggers, pin sequencing and results.
`timescale 1ns/10ps
// Notes on behaviour
// - Repeat sweep mode 1 converts the whole group endlessly, favouring priority pins.
// - One priority pin gives order pin0, pin1, pin0, pin2, pin0, pin3 and onward.
// - Software trigger: conversion begins as soon as the start flag is written 1.
// - External trigger: begin on a trigger pin falling edge after start is set.
// - Repeat sweep mode 1 runs until software writes 0 to the start flag.
// - No conversion interrupt request is ever raised in repeat sweep mode 1.
// - Priority set is pin0, pins 0-1, pins 0-2 or pins 0-3.
// - Each pin's result lands in the matching one of eight result registers.
// - Alternate pin groups behave exactly like the primary eight inputs.
// - Resolution 1 stores 10 bits in bits 9:0; resolution 0 stores 8 bits.
// - With sample-and-hold a pin takes 28 cycles at 8 bits, 33 at 10.
// - Sample-and-hold applies in every mode; software chooses it before starting.
// - Extended inputs usable only in one-shot and repeat modes via the op-amp field.
// - First extended input result goes to register 0, second to register 1.
// - Op-amp field 11 routes pin out, converts the return, stores at that pin.
module asc_sweep_ctrl
  import asc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        external_trigger_pin_i,
  input  wire logic        comparator_i,
  output logic      [2:0]  channel_select_o,
  output logic      [1:0]  input_group_select_o,
  output logic      [1:0]  ext_input_select_o,
  output logic             sample_o,
  output logic      [9:0]  sar_trial_o,
  output logic             reference_connect_o,
  output logic             conv_done_irq_o
);

  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [9:0]  result_mem [8];
  logic        ack_reg;
  logic [31:0] rdata_reg;
  asc_state_t  state_reg;
  logic [2:0]  ch_reg;
  logic [2:0]  np_reg;
  logic [1:0]  ext_sel_reg;
  logic        launch_reg;
  logic        trig_prev_reg;
  logic        irq_reg;
  logic [7:0]  ref_cnt_reg;

  logic        wr_en;
  logic        trig_fall;
  asc_mode_t   mode;
  logic        trg_ext;
  logic        start_flag;
  logic        sweep1;
  logic [2:0]  prio_last;
  logic [2:0]  sweep_last;
  logic        ext_active;
  logic        abort;
  logic        finish;
  logic        continue_run;
  logic        dev_clear_start;
  logic [2:0]  first_ch;
  logic [2:0]  next_ch;
  logic [2:0]  next_np;
  logic [2:0]  dest_idx;
  logic        eng_done;
  logic [9:0]  eng_result;
  logic        ref_ready;

  // Result slot for a conversion: extended inputs map to fixed slots.
  function automatic logic [2:0] asc_dest(input logic ext_on, input logic [1:0] opa,
                                          input logic [2:0] ch);
    if (ext_on && opa == ASC_OPA_EXT0)
      asc_dest = 3'd0;
    else if (ext_on && opa == ASC_OPA_EXT1)
      asc_dest = 3'd1;
    else
      asc_dest = ch;
  endfunction

  // Trims a raw result to the active resolution.
  function automatic logic [9:0] asc_trim(input logic ten_bit, input logic [9:0] raw);
    asc_trim = ten_bit ? raw : {2'b00, raw[7:0]};
  endfunction

  assign mode       = asc_mode_t'(ctrl0_reg[ASC_C0_MODE_LSB +: 2]);
  assign trg_ext    = ctrl0_reg[ASC_C0_TRG_BIT];
  assign start_flag = ctrl0_reg[ASC_C0_START_BIT];
  assign sweep1     = mode == ASC_MODE_SWEEP_REPEAT && ctrl1_reg[ASC_C1_SWEEP1_BIT];
  assign prio_last  = {1'b0, ctrl1_reg[ASC_C1_PRIO_LSB +: 2]};
  assign sweep_last = {ctrl1_reg[ASC_C1_PRIO_LSB +: 2], 1'b1};
  // Extended inputs are only honoured in the single-pin modes.
  assign ext_active = (mode == ASC_MODE_ONESHOT || mode == ASC_MODE_REPEAT)
                      && ctrl1_reg[ASC_C1_OPA_LSB +: 2] != ASC_OPA_NONE;

  assign wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
  assign trig_fall = trig_prev_reg && !external_trigger_pin_i;
  // A stop write aborts at the edge that takes it, so no new pin starts behind it.
  assign abort     = state_reg == ASC_ST_RUN
                     && (!start_flag || (wr_en && wb_adr_i == ASC_OFF_CTRL0
                                         && !wb_dat_i[ASC_C0_START_BIT]));

  // First pin of a run.
  always_comb
  begin
    if (mode == ASC_MODE_ONESHOT || mode == ASC_MODE_REPEAT)
      first_ch = ctrl0_reg[ASC_C0_CHAN_LSB +: 3];
    else
      first_ch = 3'd0;
  end

  // Pin order after a completed conversion.
  always_comb
  begin
    next_ch      = ch_reg;
    next_np      = np_reg;
    continue_run = 1'b1;
    case (mode)
      ASC_MODE_ONESHOT:
        continue_run = 1'b0;
      ASC_MODE_REPEAT:
        next_ch = ch_reg;
      ASC_MODE_SWEEP_SINGLE:
      begin
        continue_run = ch_reg != sweep_last;
        next_ch      = ch_reg + 3'd1;
      end
      ASC_MODE_SWEEP_REPEAT:
      begin
        if (!sweep1)
          next_ch = (ch_reg == sweep_last) ? 3'd0 : ch_reg + 3'd1;
        else if (ch_reg < prio_last)
          next_ch = ch_reg + 3'd1;
        else if (ch_reg == prio_last)
          next_ch = np_reg;
        else
        begin
          next_ch = 3'd0;
          next_np = (np_reg == 3'd7) ? prio_last + 3'd1 : np_reg + 3'd1;
        end
      end
      default:
        continue_run = 1'b0;
    endcase
  end

  assign finish          = state_reg == ASC_ST_RUN && eng_done && !continue_run;
  // The device only drops the start flag after a software-triggered finite run.
  assign dev_clear_start = finish && !trg_ext && !sweep1;
  assign dest_idx        = asc_dest(ext_active, ctrl1_reg[ASC_C1_OPA_LSB +: 2], ch_reg);

  // Wishbone slave: one wait state, ack drops in the cycle after it was given.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl0_reg <= ASC_CTRL0_RST;
    else if (wr_en && wb_adr_i == ASC_OFF_CTRL0)
      ctrl0_reg <= wb_dat_i[7:0];
    else if (dev_clear_start)
      ctrl0_reg[ASC_C0_START_BIT] <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl1_reg <= ASC_CTRL1_RST;
      ctrl2_reg <= ASC_CTRL2_RST;
    end
    else if (wr_en && wb_adr_i == ASC_OFF_CTRL1)
      ctrl1_reg <= wb_dat_i[7:0];
    else if (wr_en && wb_adr_i == ASC_OFF_CTRL2)
      ctrl2_reg <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg)
    begin
      rdata_reg <= 32'h0000_0000;
      if (wb_adr_i == ASC_OFF_CTRL0)
        rdata_reg[7:0] <= ctrl0_reg;
      else if (wb_adr_i == ASC_OFF_CTRL1)
        rdata_reg[7:0] <= ctrl1_reg;
      else if (wb_adr_i == ASC_OFF_CTRL2)
        rdata_reg[7:0] <= ctrl2_reg;
      else if (wb_adr_i == ASC_OFF_STATUS)
        rdata_reg[7:0] <= {ref_ready, ch_reg, 1'b0, 1'b0,
                           state_reg == ASC_ST_ARMED, state_reg == ASC_ST_RUN};
      else if (wb_adr_i[5] && wb_adr_i[1:0] == 2'b00)
        rdata_reg[9:0] <= result_mem[wb_adr_i[4:2]];
    end
  end

  // Reference settling tracker, shown in status so software can poll it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl1_reg[ASC_C1_REF_BIT])
      ref_cnt_reg <= 8'h00;
    else if (!ref_ready)
      ref_cnt_reg <= ref_cnt_reg + 8'h01;
  end

  assign ref_ready = ref_cnt_reg >= 8'(ASC_REF_SETTLE_CYC);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_prev_reg <= 1'b1;
    else
      trig_prev_reg <= external_trigger_pin_i;
  end

  // Run control and pin sequencing.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg   <= ASC_ST_IDLE;
      ch_reg      <= 3'd0;
      np_reg      <= 3'd1;
      ext_sel_reg <= ASC_OPA_NONE;
      launch_reg  <= 1'b0;
    end
    else
    begin
      launch_reg <= 1'b0;
      case (state_reg)
        ASC_ST_IDLE:
        begin
          if (start_flag && !trg_ext)
          begin
            state_reg   <= ASC_ST_RUN;
            launch_reg  <= 1'b1;
            ch_reg      <= first_ch;
            np_reg      <= prio_last + 3'd1;
            ext_sel_reg <= ext_active ? ctrl1_reg[ASC_C1_OPA_LSB +: 2] : ASC_OPA_NONE;
          end
          else if (start_flag)
            state_reg <= ASC_ST_ARMED;
        end
        ASC_ST_ARMED:
        begin
          if (!start_flag)
            state_reg <= ASC_ST_IDLE;
          else if (trig_fall)
          begin
            state_reg   <= ASC_ST_RUN;
            launch_reg  <= 1'b1;
            ch_reg      <= first_ch;
            np_reg      <= prio_last + 3'd1;
            ext_sel_reg <= ext_active ? ctrl1_reg[ASC_C1_OPA_LSB +: 2] : ASC_OPA_NONE;
          end
        end
        ASC_ST_RUN:
        begin
          if (abort)
            state_reg <= ASC_ST_IDLE;
          else if (eng_done && continue_run)
          begin
            ch_reg     <= next_ch;
            np_reg     <= next_np;
            launch_reg <= 1'b1;
          end
          else if (finish)
            state_reg <= trg_ext ? ASC_ST_ARMED : ASC_ST_IDLE;
        end
        default:
          state_reg <= ASC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
        result_mem[i] <= 10'h000;
    end
    else if (state_reg == ASC_ST_RUN && eng_done && !abort)
      result_mem[dest_idx] <= asc_trim(ctrl1_reg[ASC_C1_RES10_BIT], eng_result);
  end

  // Completion request only for the finite modes, never the repeating ones.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= finish
                 && (mode == ASC_MODE_ONESHOT || mode == ASC_MODE_SWEEP_SINGLE);
  end

  asc_sar_engine u_engine (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .start_i       (launch_reg),
    .abort_i       (abort),
    .ten_bit_i     (ctrl1_reg[ASC_C1_RES10_BIT]),
    .sample_hold_i (ctrl2_reg[ASC_C2_SH_BIT]),
    .comparator_i  (comparator_i),
    .busy_o        (),
    .sample_o      (sample_o),
    .trial_o       (sar_trial_o),
    .done_o        (eng_done),
    .result_o      (eng_result)
  );

  assign wb_ack_o             = ack_reg;
  assign wb_dat_o             = rdata_reg;
  assign channel_select_o     = ch_reg;
  assign input_group_select_o = ctrl2_reg[ASC_C2_GROUP_LSB +: 2];
  assign ext_input_select_o   = ext_sel_reg;
  assign reference_connect_o  = ctrl1_reg[ASC_C1_REF_BIT];
  assign conv_done_irq_o      = irq_reg;

endmodule

// file: hw/asc_pkg.sv
// Constants, register map and types shared by the converter sweep controller.
package asc_pkg;

  // Register byte offsets on the Wishbone slave (one aligned word each).
  localparam logic [5:0] ASC_OFF_CTRL0       = 6'h00;
  localparam logic [5:0] ASC_OFF_CTRL1       = 6'h04;
  localparam logic [5:0] ASC_OFF_CTRL2       = 6'h08;
  localparam logic [5:0] ASC_OFF_STATUS      = 6'h0c;
  localparam logic [5:0] ASC_OFF_RESULT_BASE = 6'h20;

  // Field positions in adc_control_zero.
  localparam int ASC_C0_CHAN_LSB  = 0;
  localparam int ASC_C0_MODE_LSB  = 3;
  localparam int ASC_C0_TRG_BIT   = 5;
  localparam int ASC_C0_START_BIT = 6;

  // Field positions in adc_control_one.
  localparam int ASC_C1_PRIO_LSB   = 0;
  localparam int ASC_C1_SWEEP1_BIT = 2;
  localparam int ASC_C1_RES10_BIT  = 3;
  localparam int ASC_C1_REF_BIT    = 5;
  localparam int ASC_C1_OPA_LSB    = 6;

  // Field positions in adc_control_two.
  localparam int ASC_C2_SH_BIT    = 0;
  localparam int ASC_C2_GROUP_LSB = 1;

  // Values after reset.
  localparam logic [7:0] ASC_CTRL0_RST = 8'h00;
  localparam logic [7:0] ASC_CTRL1_RST = 8'h00;
  localparam logic [7:0] ASC_CTRL2_RST = 8'h00;

  // Cycles per pin with sample-and-hold, and plain defaults without it.
  localparam int ASC_CYC_SH_8    = 28;
  localparam int ASC_CYC_SH_10   = 33;
  localparam int ASC_CYC_NOSH_8  = 40;
  localparam int ASC_CYC_NOSH_10 = 48;

  // Reference settling time after reconnecting, in ns, and as clock cycles.
  localparam int ASC_CLK_PERIOD_NS = 8;
  localparam int ASC_REF_SETTLE_NS = 1000;
  localparam int ASC_REF_SETTLE_CYC =
    (ASC_REF_SETTLE_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;

  localparam logic [1:0] ASC_OPA_NONE   = 2'b00;
  localparam logic [1:0] ASC_OPA_EXT0   = 2'b01;
  localparam logic [1:0] ASC_OPA_EXT1   = 2'b10;
  localparam logic [1:0] ASC_OPA_OPAMP  = 2'b11;

  typedef enum logic [1:0] {
    ASC_MODE_ONESHOT      = 2'b00,
    ASC_MODE_REPEAT       = 2'b01,
    ASC_MODE_SWEEP_SINGLE = 2'b10,
    ASC_MODE_SWEEP_REPEAT = 2'b11
  } asc_mode_t;

  typedef enum logic [2:0] {
    ASC_ST_IDLE  = 3'b001,
    ASC_ST_ARMED = 3'b010,
    ASC_ST_RUN   = 3'b100
  } asc_state_t;

endpackage

// file: hw/asc_sar_engine.sv
// Successive-approximation sequencer: sample phase then one cycle per bit.
`timescale 1ns/10ps
module asc_sar_engine
  import asc_pkg::*;
#(
  parameter int CYC_SH_8    = ASC_CYC_SH_8,
  parameter int CYC_SH_10   = ASC_CYC_SH_10,
  parameter int CYC_NOSH_8  = ASC_CYC_NOSH_8,
  parameter int CYC_NOSH_10 = ASC_CYC_NOSH_10
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       ten_bit_i,
  input  wire logic       sample_hold_i,
  input  wire logic       comparator_i,
  output logic            busy_o,
  output logic            sample_o,
  output logic [9:0]      trial_o,
  output logic            done_o,
  output logic [9:0]      result_o
);

  logic [5:0] cnt_reg;
  logic [9:0] res_reg;
  logic       busy_reg;
  logic       done_reg;
  logic [5:0] nbits;
  logic [5:0] total;
  logic [9:0] bit_mask;

  // Total per-pin time; the bits are resolved in the last cycles of it.
  always_comb
  begin
    nbits = ten_bit_i ? 6'd10 : 6'd8;
    if (sample_hold_i)
      total = ten_bit_i ? 6'(CYC_SH_10) : 6'(CYC_SH_8);
    else
      total = ten_bit_i ? 6'(CYC_NOSH_10) : 6'(CYC_NOSH_8);
  end

  // An 8-bit code is resolved on the top bits of the trial, so that both
  // resolutions span the same input range on the comparator.
  assign bit_mask = (busy_reg && cnt_reg <= nbits && cnt_reg != 6'd0)
                    ? 10'(10'h001 << (cnt_reg - 6'd1 + (ten_bit_i ? 6'd0 : 6'd2)))
                    : 10'h000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || abort_i)
    begin
      busy_reg <= 1'b0;
      cnt_reg  <= 6'd0;
      res_reg  <= 10'h000;
    end
    else if (start_i && !busy_reg)
    begin
      busy_reg <= 1'b1;
      cnt_reg  <= total;
      res_reg  <= 10'h000;
    end
    else if (busy_reg)
    begin
      if (comparator_i && bit_mask != 10'h000)
        res_reg <= res_reg | bit_mask;
      cnt_reg <= cnt_reg - 6'd1;
      if (cnt_reg == 6'd1)
        busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_reg <= 1'b0;
    else
      done_reg <= busy_reg && cnt_reg == 6'd1 && !abort_i;
  end

  assign busy_o   = busy_reg;
  assign sample_o = busy_reg && cnt_reg > nbits;
  assign trial_o  = res_reg | bit_mask;
  assign done_o   = done_reg;
  assign result_o = ten_bit_i ? res_reg : {2'b00, res_reg[9:2]};

endmodule

// file: testbench/asc_analog_model.sv
// Analog side model: pin levels, comparator, op-amp loop and trigger pin.
`timescale 1ns/10ps
module asc_analog_model
  import asc_pkg::*;
(
  input  wire logic [2:0] chan_i,
  input  wire logic [1:0] grp_i,
  input  wire logic [1:0] ext_i,
  input  wire logic [9:0] trial_i,
  input  wire logic       trig_i,
  output logic            cmp_o,
  output logic            trig_o
);
  logic [9:0] level;
  // Each pin level encodes its pin and group, so a misrouted pin cannot match.
  always_comb
  begin
    level = {chan_i, grp_i, 5'h15};
    if (ext_i == ASC_OPA_EXT0)
      level = 10'h2a5;
    if (ext_i == ASC_OPA_EXT1)
      level = 10'h15a;
  end
  assign cmp_o  = level >= trial_i;
  // The trigger line idles high, as with a pull-up on the pin.
  assign trig_o = trig_i;
endmodule

// file: testbench/asc_sweep_ctrl_props.sv
// Concurrent checks on the converter sweep controller's ports.
`timescale 1ns/10ps
module asc_sweep_ctrl_props
  import asc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        external_trigger_pin_i,
  input wire logic        sample_o,
  input wire logic [1:0]  input_group_select_o,
  input wire logic [1:0]  ext_input_select_o,
  input wire logic        conv_done_irq_o
);
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic       rd_res_q;
  logic [4:0] slen_q;
  logic       take;
  logic       wr_en;
  assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = take && wb_we_i && wb_sel_i[0];
  // Shadows change at the edge that takes the write, so an abort is seen at once.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl0_q <= ASC_CTRL0_RST;
      ctl1_q <= ASC_CTRL1_RST;
      ctl2_q <= ASC_CTRL2_RST;
    end
    else if (wr_en)
    begin
      if (wb_adr_i == ASC_OFF_CTRL0)
        ctl0_q <= wb_dat_i[7:0];
      if (wb_adr_i == ASC_OFF_CTRL1)
        ctl1_q <= wb_dat_i[7:0];
      if (wb_adr_i == ASC_OFF_CTRL2)
        ctl2_q <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_res_q <= 1'b0;
    else
      rd_res_q <= take && !wb_we_i && wb_adr_i >= ASC_OFF_RESULT_BASE;
  end
  // Saturates so that a stuck sample phase cannot wrap back to a legal length.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !sample_o)
      slen_q <= 5'd0;
    else if (slen_q != 5'h1f)
      slen_q <= slen_q + 5'd1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");
  a_sw_start: assert property (
    wr_en && wb_adr_i == ASC_OFF_CTRL0 && wb_dat_i[6] && !wb_dat_i[5]
    |-> ##[1:8] $rose(sample_o))
    else $error("software start did not begin a conversion");
  a_ext_start: assert property (
    $fell(external_trigger_pin_i) && ctl0_q[5] && ctl0_q[6] |-> ##[1:10] $rose(sample_o))
    else $error("trigger falling edge did not begin a conversion");
  a_stop_halt: assert property (!ctl0_q[6] |-> !$rose(sample_o))
    else $error("conversion began with the start flag cleared");
  a_no_irq: assert property (ctl0_q[4:3] == 2'b11 && ctl1_q[2] |-> !conv_done_irq_o)
    else $error("interrupt request raised in repeat sweep mode 1");
  a_read_width: assert property (
    wb_ack_o && rd_res_q
    |-> wb_dat_o[31:10] == 22'h0 && (ctl1_q[3] || wb_dat_o[9:8] == 2'h0))
    else $error("result wider than the selected resolution");
  a_sample_len: assert property (
    $fell(sample_o) && ctl2_q[0] && ctl0_q[6] |-> slen_q == (ctl1_q[3] ? 5'd23 : 5'd20))
    else $error("sample phase length wrong for the resolution");
  a_ext_sweep: assert property (
    $rose(sample_o) && ctl0_q[4] |-> ext_input_select_o == ASC_OPA_NONE)
    else $error("extended input routed in a sweep mode");
  a_opamp_route: assert property (
    $rose(sample_o) && !ctl0_q[4] |-> ext_input_select_o == ctl1_q[7:6])
    else $error("extended input route differs from the field");
  a_group_out: assert property (
    $rose(sample_o) |-> input_group_select_o == ctl2_q[2:1])
    else $error("pin group differs from the group field");
endmodule
bind asc_sweep_ctrl asc_sweep_ctrl_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_trigger_pin_i(external_trigger_pin_i),
  .sample_o(sample_o), .input_group_select_o(input_group_select_o),
  .ext_input_select_o(ext_input_select_o), .conv_done_irq_o(conv_done_irq_o));

// file: testbench/asc_sweep_ctrl_test.sv
// Self-checking bench for the converter sweep controller.
`timescale 1ns/10ps
module asc_sweep_ctrl_test;
  import asc_pkg::*;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        trig     = 1'b1;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, external_trigger_pin_i, comparator_i, sample_o;
  logic        reference_connect_o, conv_done_irq_o;
  logic [2:0]  channel_select_o;
  logic [1:0]  input_group_select_o, ext_input_select_o;
  logic [9:0]  sar_trial_o;
  logic [2:0]  seq[$];
  int          slen = 0;
  int          last_len = 0;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [5:0]  roff[4] = '{6'h38, 6'h20, 6'h24, 6'h38};
  logic [31:0] rexp[4] = '{32'h375, 32'h2a5, 32'h15a, 32'h375};

  asc_sweep_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_trigger_pin_i(external_trigger_pin_i),
    .comparator_i(comparator_i), .channel_select_o(channel_select_o),
    .input_group_select_o(input_group_select_o), .ext_input_select_o(ext_input_select_o),
    .sample_o(sample_o), .sar_trial_o(sar_trial_o), .reference_connect_o(reference_connect_o),
    .conv_done_irq_o(conv_done_irq_o));
  asc_analog_model u_ana (
    .chan_i(channel_select_o), .grp_i(input_group_select_o), .ext_i(ext_input_select_o),
    .trial_i(sar_trial_o), .trig_i(trig), .cmp_o(comparator_i),
    .trig_o(external_trigger_pin_i));

  always #4 clk_i = ~clk_i;

  // Logs the pin at each sample start and the length of the last sample phase.
  always @(posedge clk_i)
  begin
    if (sample_o === 1'b1)
    begin
      if (slen == 0)
        seq.push_back(channel_select_o);
      slen <= slen + 1;
    end
    else if (slen != 0)
    begin
      last_len <= slen;
      slen <= 0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1)
      num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Waits for n logged samples, or for the done pulse when n is zero.
  task automatic hold(input int n);
    int t;
    t = 0;
    while ((n > 0 ? seq.size() < n : conv_done_irq_o !== 1'b1) && t < 2000)
    begin
      @(posedge clk_i);
      t++;
    end
    if (t == 2000)
      num_errors++;
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    int n, j, e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(ASC_OFF_CTRL0, 32'h0);
    rdc(ASC_OFF_CTRL1, 32'h0);
    rdc(ASC_OFF_CTRL2, 32'h0);
    bus(1'b1, 6'h14, 32'hff);
    rdc(6'h14, 32'h0);
    bus(1'b1, ASC_OFF_CTRL1, 32'h20);
    chk(32'(reference_connect_o), 32'h1);
    repeat (ASC_REF_SETTLE_CYC) @(posedge clk_i);
    rdc(ASC_OFF_STATUS, 32'h80);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, ASC_OFF_CTRL2, 32'(2 * c + 1));
      bus(1'b1, ASC_OFF_CTRL1, 32'h64 + 32'(c));
      seq.delete();
      bus(1'b1, ASC_OFF_CTRL0, 32'h58);
      hold(21);
      bus(1'b0, ASC_OFF_CTRL0, 32'h0);
      chk(32'(q[6]), 32'h1);
      bus(1'b1, ASC_OFF_CTRL0, 32'h18);
      n = seq.size();
      repeat (80) @(posedge clk_i);
      chk(32'(seq.size()), 32'(n));
      for (int k = 0; k < 20; k++)
      begin
        j = k % (c + 2);
        e = (j <= c) ? j : c + 1 + (k / (c + 2)) % (7 - c);
        chk(32'(seq[k]), 32'(e));
      end
      for (int i = 0; i < 8; i++)
        rdc(6'(ASC_OFF_RESULT_BASE + 4 * i), 32'({3'(i), 2'(c), 3'h5}));
    end
    // The trigger falls before arming, so only a later fall may start it.
    bus(1'b1, ASC_OFF_CTRL1, 32'h20);
    trig <= 1'b0;
    seq.delete();
    bus(1'b1, ASC_OFF_CTRL0, 32'h63);
    repeat (20) @(posedge clk_i);
    chk(32'(seq.size()), 32'h0);
    trig <= 1'b1;
    repeat (3) @(posedge clk_i);
    trig <= 1'b0;
    hold(0);
    chk(32'(last_len), 32'd20);
    rdc(6'h2c, 32'h7d);
    bus(1'b1, ASC_OFF_CTRL0, 32'h0);
    for (int o = 0; o < 4; o++)
    begin
      bus(1'b1, ASC_OFF_CTRL1, 32'h28 + 32'(64 * o));
      bus(1'b1, ASC_OFF_CTRL0, 32'h46);
      hold(0);
      chk(32'(last_len), 32'd23);
      rdc(roff[o], rexp[o]);
    end
    give_verdict();
  end
endmodule
